// *** hdl/debug_link_pkg.sv ***
/*
  shared constants for the two-wire debug link register selector:
  link addresses, unlock codes, flash command codes, reset values,
  frame counts and the frame state encoding.
  assumes nothing beyond a systemverilog compiler.
*/
package debug_link_pkg;
  // link data register addresses
  localparam logic [7:0] ADDR_PART_ID = 8'h00;
  localparam logic [7:0] ADDR_REVISION = 8'h01;
  localparam logic [7:0] ADDR_UNLOCK_CTRL = 8'h02;
  localparam logic [7:0] ADDR_PROG_PORT = 8'hBF;
  localparam logic [7:0] ADDR_CK_AUTO_CTRL = 8'hD2;
  localparam logic [7:0] ADDR_CK_COUNT = 8'hD3;
  localparam logic [7:0] ADDR_CK_CONTROL = 8'hCE;
  localparam logic [7:0] ADDR_CK_RESULT = 8'hDE;
  localparam logic [7:0] ADDR_CK_BIT_REVERSE = 8'hCF;
  localparam logic [7:0] ADDR_CK_INPUT = 8'hDD;
  // unlock sequence codes, written in this order
  localparam logic [7:0] UNLOCK_FIRST = 8'h02;
  localparam logic [7:0] UNLOCK_SECOND = 8'h01;
  // flash commands carried by the programming data port
  localparam logic [7:0] CMD_BLOCK_READ = 8'h06;
  localparam logic [7:0] CMD_BLOCK_WRITE = 8'h07;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h08;
  localparam logic [7:0] CMD_DEVICE_ERASE = 8'h03;
  // reset values and neutral read value
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [2:0] COUNT_RESET = 3'h0;
  // last bit index of the instruction field and of a data byte
  localparam logic [2:0] INSTR_LAST = 3'h1;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  // frame states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_INSTR = 5'b00010,
    ST_WDATA = 5'b00100,
    ST_LOAD = 5'b01000,
    ST_RDATA = 5'b10000
  } frame_state_e;
endpackage

// *** hdl/debug_link_register_select.sv ***
/*
  register selection and flash programming unlock behind a two-wire
  debug link: a link clock input from the programmer and a two-way data
  line. holds the link target address and the unlock control register,
  answers the identification and revision reads, and forwards accesses
  for the programming data port and checksum registers to the outside.
  assumes the link clock is much slower than clk (bench: 160 ns) and that
  ext_rdata is driven on clk, valid in the cycle ext_rd is high.
*/
// How it works
// - address register selects data read/write target
// - address 0x00 reads part identification, read-only
// - address 0x01 reads silicon revision, read-only
// - address 0x02 reaches unlock control register
// - address 0xBF reaches programming data port
// - six checksum addresses forward to checksum unit
// - part identification always returns fixed code
// - revision code set per silicon revision
// - programming port blocked until unlocked
// - unlock only on 0x02 then 0x01
// - unlocked state holds until system reset
// - link uses data line plus input clock
// - port carries flash commands, addresses, data
module debug_link_register_select #(
  parameter logic [7:0] PART_ID = 8'h5A, // arbitrary value
  parameter logic [7:0] SILICON_REVISION = 8'h00
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic debug_clock_line,
  input wire logic debug_data_line_in,
  output logic debug_data_line_out,
  output logic debug_data_line_oe,
  output logic [7:0] ext_addr,
  output logic [7:0] ext_wdata,
  output logic ext_wr,
  output logic ext_rd,
  input wire logic [7:0] ext_rdata,
  output logic programming_enabled
);
  logic clk_sync1_reg, clk_sync2_reg, clk_prev_reg;
  logic data_sync1_reg, data_sync2_reg;
  logic link_edge;
  debug_link_pkg::frame_state_e state_reg;
  logic [2:0] count_reg;
  logic is_write_reg, is_addr_reg;
  logic [7:0] shift_reg;
  logic [7:0] link_target_address_reg;
  logic [7:0] programming_unlock_control_reg;
  logic unlock_armed_reg;
  logic [7:0] wdata_next;
  logic [7:0] read_value;
  logic wr_done, rd_start, ext_hit, ext_allowed;

  // two-flop synchronisers for both link pins, then a third flop for edges
  always_ff @(posedge clk)
  begin
    clk_sync1_reg <= debug_clock_line;
    clk_sync2_reg <= clk_sync1_reg;
    clk_prev_reg <= clk_sync2_reg;
    data_sync1_reg <= debug_data_line_in;
    data_sync2_reg <= data_sync1_reg;
  end

  // rising link clock edge seen in clk domain
  assign link_edge = clk_sync2_reg & ~clk_prev_reg;
  assign wdata_next = {data_sync2_reg, shift_reg[7:1]};
  assign wr_done = (state_reg == debug_link_pkg::ST_WDATA) && link_edge && (count_reg == debug_link_pkg::BYTE_LAST);
  assign rd_start = (state_reg == debug_link_pkg::ST_INSTR) && link_edge && (count_reg == debug_link_pkg::INSTR_LAST)
                    && !is_write_reg;

  // forwarded addresses: programming port and the checksum unit
  always_comb
  begin
    unique case (link_target_address_reg)
      debug_link_pkg::ADDR_PROG_PORT: ext_hit = 1'b1;
      debug_link_pkg::ADDR_CK_AUTO_CTRL, debug_link_pkg::ADDR_CK_COUNT,
      debug_link_pkg::ADDR_CK_CONTROL, debug_link_pkg::ADDR_CK_RESULT,
      debug_link_pkg::ADDR_CK_BIT_REVERSE, debug_link_pkg::ADDR_CK_INPUT: ext_hit = 1'b1;
      default: ext_hit = 1'b0;
    endcase
  end

  // the port stays shut until unlocked
  assign ext_allowed = ext_hit && ((link_target_address_reg != debug_link_pkg::ADDR_PROG_PORT)
                       || programming_enabled);

  // read data selection by the target address
  always_comb
  begin
    read_value = debug_link_pkg::RESET_BYTE;
    if (is_addr_reg)
      read_value = link_target_address_reg;
    else if (link_target_address_reg == debug_link_pkg::ADDR_PART_ID)
      read_value = PART_ID;
    else if (link_target_address_reg == debug_link_pkg::ADDR_REVISION)
      read_value = SILICON_REVISION;
    else if (link_target_address_reg == debug_link_pkg::ADDR_UNLOCK_CTRL)
      read_value = programming_unlock_control_reg;
    else if (ext_allowed)
      read_value = ext_rdata;
  end

  // frame sequencing: start bit low, write flag, address flag, byte
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_reg <= debug_link_pkg::ST_IDLE;
      count_reg <= debug_link_pkg::COUNT_RESET;
      is_write_reg <= 1'b0;
      is_addr_reg <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        debug_link_pkg::ST_IDLE:
          if (link_edge && !data_sync2_reg)
          begin
            state_reg <= debug_link_pkg::ST_INSTR;
            count_reg <= debug_link_pkg::COUNT_RESET;
          end
        debug_link_pkg::ST_INSTR:
          if (link_edge)
          begin
            count_reg <= count_reg + 3'h1;
            if (count_reg == debug_link_pkg::COUNT_RESET)
              is_write_reg <= data_sync2_reg;
            else
            begin
              is_addr_reg <= data_sync2_reg;
              count_reg <= debug_link_pkg::COUNT_RESET;
              state_reg <= is_write_reg ? debug_link_pkg::ST_WDATA : debug_link_pkg::ST_LOAD;
            end
          end
        debug_link_pkg::ST_WDATA:
          if (link_edge)
          begin
            count_reg <= count_reg + 3'h1;
            if (count_reg == debug_link_pkg::BYTE_LAST)
              state_reg <= debug_link_pkg::ST_IDLE;
          end
        debug_link_pkg::ST_LOAD:
          state_reg <= debug_link_pkg::ST_RDATA;
        debug_link_pkg::ST_RDATA:
          if (link_edge)
          begin
            count_reg <= count_reg + 3'h1;
            if (count_reg == debug_link_pkg::BYTE_LAST)
              state_reg <= debug_link_pkg::ST_IDLE;
          end
      endcase
    end
  end

  // shift register: lsb first in on writes, loaded then shifted on reads
  always_ff @(posedge clk)
  begin
    if (reset)
      shift_reg <= debug_link_pkg::RESET_BYTE;
    else if (state_reg == debug_link_pkg::ST_WDATA && link_edge)
      shift_reg <= wdata_next;
    else if (state_reg == debug_link_pkg::ST_LOAD)
      shift_reg <= read_value;
    else if (state_reg == debug_link_pkg::ST_RDATA && link_edge)
      shift_reg <= {1'b0, shift_reg[7:1]};
  end

  // data line driver: drives during the read byte only
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      debug_data_line_out <= 1'b0;
      debug_data_line_oe <= 1'b0;
    end
    else if (state_reg == debug_link_pkg::ST_LOAD)
    begin
      debug_data_line_out <= read_value[0];
      debug_data_line_oe <= 1'b1;
    end
    else if (state_reg == debug_link_pkg::ST_RDATA && link_edge)
    begin
      debug_data_line_out <= shift_reg[1];
      if (count_reg == debug_link_pkg::BYTE_LAST)
        debug_data_line_oe <= 1'b0;
    end
  end

  // link target address register
  always_ff @(posedge clk)
  begin
    if (reset)
      link_target_address_reg <= debug_link_pkg::RESET_BYTE;
    else if (wr_done && is_addr_reg)
      link_target_address_reg <= wdata_next;
  end

  // unlock control register and its two-step sequence
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      programming_unlock_control_reg <= debug_link_pkg::RESET_BYTE;
      unlock_armed_reg <= 1'b0;
      programming_enabled <= 1'b0;
    end
    else if (wr_done && !is_addr_reg && link_target_address_reg == debug_link_pkg::ADDR_UNLOCK_CTRL)
    begin
      programming_unlock_control_reg <= wdata_next;
      unlock_armed_reg <= (wdata_next == debug_link_pkg::UNLOCK_FIRST);
      if (unlock_armed_reg && wdata_next == debug_link_pkg::UNLOCK_SECOND)
        programming_enabled <= 1'b1;
    end
  end

  // forwarded strobes toward programming port and checksum unit
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ext_wr <= 1'b0;
      ext_rd <= 1'b0;
      ext_wdata <= debug_link_pkg::RESET_BYTE;
    end
    else
    begin
      ext_wr <= wr_done && !is_addr_reg && ext_allowed;
      ext_rd <= rd_start && !data_sync2_reg && ext_allowed;
      if (wr_done && !is_addr_reg)
        ext_wdata <= wdata_next;
    end
  end

  assign ext_addr = link_target_address_reg;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_read_load;
    state_reg == debug_link_pkg::ST_LOAD;
  endsequence
  sequence s_driving;
    debug_data_line_oe && state_reg == debug_link_pkg::ST_RDATA;
  endsequence

  a_addr_write: assert property (wr_done && is_addr_reg |=> link_target_address_reg == $past(wdata_next))
    else $error("address register missed a write");
  a_part_id_read: assert property (s_read_load and (!is_addr_reg && link_target_address_reg ==
    debug_link_pkg::ADDR_PART_ID) |=> shift_reg == PART_ID)
    else $error("part identification read wrong");
  a_revision_read: assert property (s_read_load and (!is_addr_reg && link_target_address_reg ==
    debug_link_pkg::ADDR_REVISION) |=> shift_reg == SILICON_REVISION)
    else $error("revision read wrong");
  a_ctrl_write: assert property (wr_done && !is_addr_reg && link_target_address_reg == debug_link_pkg::ADDR_UNLOCK_CTRL
    |=> programming_unlock_control_reg == $past(wdata_next))
    else $error("control register missed a write");
  a_port_locked: assert property ((ext_wr || ext_rd) && ext_addr == debug_link_pkg::ADDR_PROG_PORT
    |-> programming_enabled)
    else $error("programming port reached while locked");
  a_strobe_target: assert property (ext_wr || ext_rd |-> ext_addr == debug_link_pkg::ADDR_PROG_PORT ||
    ext_addr == debug_link_pkg::ADDR_CK_AUTO_CTRL || ext_addr == debug_link_pkg::ADDR_CK_COUNT ||
    ext_addr == debug_link_pkg::ADDR_CK_CONTROL || ext_addr == debug_link_pkg::ADDR_CK_RESULT ||
    ext_addr == debug_link_pkg::ADDR_CK_BIT_REVERSE || ext_addr == debug_link_pkg::ADDR_CK_INPUT)
    else $error("strobe to an unforwarded address");
  a_unlock_pair: assert property ($rose(programming_enabled) |-> $past(unlock_armed_reg) &&
    programming_unlock_control_reg == debug_link_pkg::UNLOCK_SECOND)
    else $error("unlock without ordered pair");
  a_enable_sticky: assert property (programming_enabled |=> programming_enabled)
    else $error("programming enable dropped without reset");
  a_read_drive: assert property (s_read_load |=> s_driving)
    else $error("data line not driven for read");
  a_reset_clear: assert property ($past(reset) |-> link_target_address_reg == debug_link_pkg::RESET_BYTE &&
    programming_unlock_control_reg == debug_link_pkg::RESET_BYTE && !programming_enabled)
    else $error("registers not cleared by reset");
endmodule

// *** verif/link_programmer.sv ***
/*
  programmer model for the two-wire debug link: makes the link clock and
  drives or releases the data wire, and works out the wire level.
  assumes the bench clk paces it; the wire has a pull-up.
*/
module link_programmer (
  input wire logic clk,
  input wire logic dev_out,
  input wire logic dev_oe,
  output logic link_clk,
  output logic wire_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic host_oe;
  logic host_bit;

  // link clock idles low, host starts released
  initial
  begin
    link_clk = 1'b0;
    host_oe = 1'b0;
    host_bit = 1'b1;
  end

  // wire level: device first, then host, else the pull-up
  assign wire_lvl = dev_oe ? dev_out : (host_oe ? host_bit : 1'b1);

  // one bit: data set in the low phase, sampled just before the rise
  task automatic bit_cycle(input logic drive, input logic b, output logic seen);
    @(posedge clk);
    link_clk <= 1'b0;
    host_oe <= drive;
    host_bit <= b;
    repeat (4) @(posedge clk);
    seen = wire_lvl;
    link_clk <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  // start bit, write flag, address flag, then eight bits lsb first
  task automatic frame(input logic w, input logic a, input logic [7:0] wb, output logic [7:0] rb);
    logic s;
    bit_cycle(1'b1, 1'b0, s);
    bit_cycle(1'b1, w, s);
    bit_cycle(1'b1, a, s);
    for (int i = 0; i < 8; i++)
    begin
      bit_cycle(w, wb[i], s);
      rb[i] = s;
    end
    @(posedge clk);
    link_clk <= 1'b0;
    host_oe <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
endmodule

// *** verif/debug_link_register_select_test.sv ***
/*
  self-checking bench for the debug link register selector: link frames
  through the programmer model, forwarded accesses seen on the ext ports.
  assumes the package constants and the frame format of the design.
*/
module debug_link_register_select_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ID_VAL = 8'h3C; // arbitrary value
  localparam logic [7:0] REV_VAL = 8'h4B;
  logic clk, reset, link_clk, wire_lvl, dout, doe, ext_wr, ext_rd, prog_en;
  logic [7:0] ext_addr, ext_wdata, ext_rdata, v, wr_target;
  logic [7:0] cs_addr [6];
  logic [7:0] cmds [4];
  int err_total, checks_done, wr_count, rd_count, n, m;

  debug_link_register_select #(.PART_ID(ID_VAL), .SILICON_REVISION(REV_VAL)) u_dut (
    .clk(clk), .reset(reset), .debug_clock_line(link_clk), .debug_data_line_in(wire_lvl),
    .debug_data_line_out(dout), .debug_data_line_oe(doe), .ext_addr(ext_addr),
    .ext_wdata(ext_wdata), .ext_wr(ext_wr), .ext_rd(ext_rd), .ext_rdata(ext_rdata),
    .programming_enabled(prog_en));

  link_programmer u_prog (.clk(clk), .dev_out(dout), .dev_oe(doe), .link_clk(link_clk), .wire_lvl(wire_lvl));

  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // forwarded units answer with a pattern of the address; writes counted
  always @(posedge clk)
  begin
    ext_rdata <= ext_addr ^ 8'hA5;
    if (ext_rd === 1'b1)
      rd_count++;
    if (ext_wr === 1'b1)
    begin
      wr_count++;
      wr_target = ext_addr;
    end
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask

  task automatic set_target(input logic [7:0] a);
    logic [7:0] d;
    u_prog.frame(1'b1, 1'b1, a, d);
  endtask

  task automatic wdata(input logic [7:0] b);
    logic [7:0] d;
    u_prog.frame(1'b1, 1'b0, b, d);
  endtask

  task automatic do_reset();
    @(posedge clk);
    reset <= 1'b1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic tally_and_finish();
    if (err_total == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // watchdog against a hung frame
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end

  // main sequence
  initial
  begin
    reset = 1'b1;
    cs_addr = '{8'hD2, 8'hD3, 8'hCE, 8'hDE, 8'hCF, 8'hDD};
    cmds = '{8'h06, 8'h07, 8'h08, 8'h03};
    do_reset();
    chk("prog_en", 8'h00, {7'h00, prog_en});
    u_prog.frame(1'b0, 1'b1, 8'h00, v);
    chk("target", 8'h00, v);
    set_target(debug_link_pkg::ADDR_PART_ID);
    wdata(8'h55);
    u_prog.frame(1'b0, 1'b0, 8'h00, v);
    chk("part_id", ID_VAL, v);
    set_target(debug_link_pkg::ADDR_REVISION);
    wdata(8'h55);
    u_prog.frame(1'b0, 1'b0, 8'h00, v);
    chk("revision", REV_VAL, v);
    u_prog.frame(1'b0, 1'b1, 8'h00, v);
    chk("target", debug_link_pkg::ADDR_REVISION, v);
    set_target(debug_link_pkg::ADDR_PROG_PORT);
    n = wr_count;
    m = rd_count;
    wdata(debug_link_pkg::CMD_BLOCK_READ);
    u_prog.frame(1'b0, 1'b0, 8'h00, v);
    chk("locked port", 8'h00, v);
    chk("locked strobes", n[7:0], wr_count[7:0]);
    chk("locked reads", m[7:0], rd_count[7:0]);
    set_target(8'h10);
    u_prog.frame(1'b0, 1'b0, 8'h00, v);
    chk("unmapped read", 8'h00, v);
    chk("unmapped reads", m[7:0], rd_count[7:0]);
    set_target(debug_link_pkg::ADDR_UNLOCK_CTRL);
    wdata(debug_link_pkg::UNLOCK_SECOND);
    wdata(debug_link_pkg::UNLOCK_FIRST);
    wdata(8'h05);
    wdata(debug_link_pkg::UNLOCK_SECOND);
    chk("prog_en", 8'h00, {7'h00, prog_en});
    u_prog.frame(1'b0, 1'b0, 8'h00, v);
    chk("ctrl", debug_link_pkg::UNLOCK_SECOND, v);
    wdata(debug_link_pkg::UNLOCK_FIRST);
    wdata(debug_link_pkg::UNLOCK_SECOND);
    chk("prog_en", 8'h01, {7'h00, prog_en});
    wdata(8'h00);
    chk("prog_en", 8'h01, {7'h00, prog_en});
    // every checksum address forwards writes and reads
    for (int i = 0; i < 6; i++)
    begin
      set_target(cs_addr[i]);
      wdata(cs_addr[i] ^ 8'h3C);
      chk("cs wr addr", cs_addr[i], wr_target);
      chk("cs wdata", cs_addr[i] ^ 8'h3C, ext_wdata);
      m = rd_count;
      u_prog.frame(1'b0, 1'b0, 8'h00, v);
      chk("cs rdata", cs_addr[i] ^ 8'hA5, v);
      chk("cs reads", m[7:0] + 8'h01, rd_count[7:0]);
    end
    // unlocked port passes each flash command through
    set_target(debug_link_pkg::ADDR_PROG_PORT);
    for (int i = 0; i < 4; i++)
    begin
      n = wr_count;
      wdata(cmds[i]);
      chk("port wdata", cmds[i], ext_wdata);
      chk("port strobes", n[7:0] + 8'h01, wr_count[7:0]);
    end
    u_prog.frame(1'b0, 1'b0, 8'h00, v);
    chk("port rdata", debug_link_pkg::ADDR_PROG_PORT ^ 8'hA5, v);
    do_reset();
    chk("prog_en", 8'h00, {7'h00, prog_en});
    chk("ext_addr", 8'h00, ext_addr);
    set_target(debug_link_pkg::ADDR_UNLOCK_CTRL);
    u_prog.frame(1'b0, 1'b0, 8'h00, v);
    chk("ctrl", 8'h00, v);
    tally_and_finish();
  end
endmodule
